// *** logic/rtcg_pkg.sv ***
package rtcg_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] PCE_A_OFFSET = 8'h00;
  localparam logic [7:0] RTC_CTRL_A_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_1H_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_REQ_1H_OFFSET = 8'h0C;
  localparam logic [7:0] TIME_VIEW_OFFSET = 8'h10;

  // Field positions
  localparam int CLK_SUPPLY_BIT = 7;
  localparam int RUN_BIT = 7;
  localparam int HZ_OUT_BIT = 5;
  localparam int AMPM_BIT = 3;
  localparam int RTC_IRQ_BIT = 1;
  localparam logic [7:0] RTC_CTRL_WMASK = 8'hAF;

  // Reset values
  localparam logic [7:0] PCE_A_RESET = 8'h00;
  localparam logic [7:0] RTC_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_1H_RESET = 8'hFF;
  localparam logic [7:0] IRQ_REQ_1H_RESET = 8'h00;

  // Fixed-cycle interrupt selection codes
  localparam logic [2:0] CYC_NONE = 3'h0;
  localparam logic [2:0] CYC_HALF_SEC = 3'h1;
  localparam logic [2:0] CYC_SEC = 3'h2;
  localparam logic [2:0] CYC_MIN = 3'h3;
  localparam logic [2:0] CYC_HOUR = 3'h4;
  localparam logic [2:0] CYC_DAY = 3'h5;

  // Timing
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int DAYS_PER_MONTH = 31;

  typedef struct packed {
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcg_time_t;

  typedef struct packed {
    logic rtcClockOn;
    logic rtcInReset;
    logic intervalTimerClockOn;
    logic rtcRunning;
  } rtcg_status_t;
endpackage

// *** logic/rtcg_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE1: Supply bit 0 stops RTC clock and holds RTC in reset.
// RULE2: Supply bit 0 makes writes to RTC registers ignored.
// RULE3: Supply bit 1 supplies the clock and allows RTC register access.
// RULE4: Supply bit is bit 7 of enable register; also gates interval timer.
// RULE5: Run bit 7 of control register stops counters at 0, counts at 1.
// RULE6: Mask bit 1 enables RTC interrupt at 0, blocks at 1.
// RULE7: Pending bit 1 reads 1 while request pending; software writes 0 to clear.
// RULE8: Selection 010 raises interrupt once per second with the seconds increment.
// RULE9: Control bits 6 and 4 read zero and ignore writes.
module rtcg_top
  import rtcg_pkg::*;
#(
  parameter int SEC_CYCLES_P = rtcg_pkg::SEC_CYCLES,
  parameter int DAYS_P = rtcg_pkg::DAYS_PER_MONTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // RTC side
  output rtcg_pkg::rtcg_status_t status,
  output rtcg_pkg::rtcg_time_t timeNow,
  output logic rtcFixedCycleIrq,
  output logic rtcIrqRequest,
  output logic rtc1HzOut
);
  import rtcg_pkg::*;

  logic [7:0] pceA;
  logic [7:0] rtcCtrlA;
  logic [7:0] irqMask1h;
  logic [7:0] irqReq1h;
  logic wrPend;
  logic rdPend;
  logic rdValid;
  logic [7:0] addrQ;
  logic accept;
  logic supplyOn;
  logic run;
  logic [31:0] presc;
  logic secTick;
  logic halfTick;
  logic fixedEvent;
  logic [31:0] readMux;

  assign accept = hsel & hready & htrans[1];
  assign supplyOn = pceA[CLK_SUPPLY_BIT];
  assign run = supplyOn & rtcCtrlA[RUN_BIT];
  assign hresp = 1'b0;
  assign hreadyout = ~rdPend | rdValid;
  assign status.rtcClockOn = supplyOn; // RULE1 RULE3
  assign status.rtcInReset = ~supplyOn; // RULE1
  assign status.intervalTimerClockOn = supplyOn; // RULE4
  assign status.rtcRunning = run;

  // Address phase capture; reads take one wait state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      rdValid <= 1'b0;
      addrQ <= 8'h00;
    end else begin
      if (hready) begin
        wrPend <= accept & hwrite;
        rdPend <= accept & ~hwrite;
        rdValid <= 1'b0;
        if (accept) begin
          addrQ <= haddr[7:0];
        end
      end else begin
        rdValid <= rdPend;
      end
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (addrQ)
      PCE_A_OFFSET: readMux = {24'h00_0000, pceA};
      RTC_CTRL_A_OFFSET: readMux = {24'h00_0000, rtcCtrlA}; // RULE3
      IRQ_MASK_1H_OFFSET: readMux = {24'h00_0000, irqMask1h};
      IRQ_REQ_1H_OFFSET: readMux = {24'h00_0000, irqReq1h}; // RULE7
      TIME_VIEW_OFFSET: readMux = {10'h000, timeNow};
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend && !rdValid) begin
      hrdata <= readMux;
    end
  end

  // Peripheral enable register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pceA <= PCE_A_RESET;
    end else if (wrPend && addrQ == PCE_A_OFFSET) begin
      pceA <= hwdata[7:0]; // RULE4
    end
  end

  // RTC control register: reset while unclocked, writes blocked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rtcCtrlA <= RTC_CTRL_A_RESET;
    end else if (!supplyOn) begin
      rtcCtrlA <= RTC_CTRL_A_RESET; // RULE1 RULE2
    end else if (wrPend && addrQ == RTC_CTRL_A_OFFSET) begin
      rtcCtrlA <= hwdata[7:0] & RTC_CTRL_WMASK; // RULE3 RULE9
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask1h <= IRQ_MASK_1H_RESET;
    end else if (wrPend && addrQ == IRQ_MASK_1H_OFFSET) begin
      irqMask1h <= hwdata[7:0];
    end
  end

  // Interrupt request register; a new event wins over a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqReq1h <= IRQ_REQ_1H_RESET;
    end else begin
      if (wrPend && addrQ == IRQ_REQ_1H_OFFSET) begin
        irqReq1h <= hwdata[7:0]; // RULE7
      end
      if (fixedEvent) begin
        irqReq1h[RTC_IRQ_BIT] <= 1'b1; // RULE7
      end
    end
  end

  assign rtcIrqRequest = irqReq1h[RTC_IRQ_BIT] & ~irqMask1h[RTC_IRQ_BIT]; // RULE6

  // Prescaler from the core clock down to seconds
  assign secTick = run && presc == 32'(SEC_CYCLES_P - 1); // RULE5
  assign halfTick = secTick || (run && presc == 32'(SEC_CYCLES_P / 2 - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc <= 32'h0000_0000;
    end else if (!supplyOn) begin
      presc <= 32'h0000_0000; // RULE1
    end else if (run) begin
      presc <= secTick ? 32'h0000_0000 : presc + 32'h0000_0001; // RULE5
    end
  end

  // Time counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeNow <= '0;
    end else if (!supplyOn) begin
      timeNow <= '0; // RULE1
    end else if (secTick) begin
      if (timeNow.sec == 6'd59) begin
        timeNow.sec <= 6'd0;
        if (timeNow.min == 6'd59) begin
          timeNow.min <= 6'd0;
          if (timeNow.hour == 5'd23) begin
            timeNow.hour <= 5'd0;
            timeNow.day <= (timeNow.day == 5'(DAYS_P - 1)) ? 5'd0 : timeNow.day + 5'd1;
          end else begin
            timeNow.hour <= timeNow.hour + 5'd1;
          end
        end else begin
          timeNow.min <= timeNow.min + 6'd1;
        end
      end else begin
        timeNow.sec <= timeNow.sec + 6'd1; // RULE5
      end
    end
  end

  // Fixed-cycle event selection
  always_comb begin
    fixedEvent = 1'b0;
    case (rtcCtrlA[2:0])
      CYC_NONE: fixedEvent = 1'b0;
      CYC_HALF_SEC: fixedEvent = halfTick;
      CYC_SEC: fixedEvent = secTick; // RULE8
      CYC_MIN: fixedEvent = secTick && timeNow.sec == 6'd59;
      CYC_HOUR: fixedEvent = secTick && timeNow.sec == 6'd59 && timeNow.min == 6'd59;
      CYC_DAY: fixedEvent = secTick && timeNow.sec == 6'd59 && timeNow.min == 6'd59 && timeNow.hour == 5'd23;
      default: fixedEvent = secTick && timeNow.sec == 6'd59 && timeNow.min == 6'd59 && timeNow.hour == 5'd23
        && timeNow.day == 5'(DAYS_P - 1);
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rtcFixedCycleIrq <= 1'b0;
      rtc1HzOut <= 1'b0;
    end else begin
      rtcFixedCycleIrq <= fixedEvent; // RULE8
      rtc1HzOut <= run && rtcCtrlA[HZ_OUT_BIT] && presc < 32'(SEC_CYCLES_P / 2);
    end
  end
endmodule // rtcg_top
`default_nettype wire

// *** verification/rtcg_top_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtcg_chk
  import rtcg_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire rtcg_pkg::rtcg_status_t status,
  input wire rtcg_pkg::rtcg_time_t timeNow,
  input wire logic rtcFixedCycleIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence rdReq; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence rdAns; !hreadyout ##1 hreadyout; endsequence
  a_off_in_reset: assert property (!status.rtcClockOn |-> status.rtcInReset) else $error("off not reset");
  a_off_time_zero: assert property (!status.rtcClockOn && $past(!status.rtcClockOn) |-> timeNow == '0)
    else $error("time kept");
  a_off_no_run: assert property (!status.rtcClockOn |-> !status.rtcRunning) else $error("run while off");
  a_timer_gated: assert property (status.intervalTimerClockOn == status.rtcClockOn) else $error("timer gate");
  a_stop_holds: assert property (!status.rtcRunning |=> $stable(timeNow) || !status.rtcClockOn)
    else $error("counted stopped");
  a_pulse_needs_run: assert property (rtcFixedCycleIrq |-> $past(status.rtcRunning)) else $error("pulse idle");
  a_pulse_one: assert property (rtcFixedCycleIrq |=> !rtcFixedCycleIrq) else $error("pulse long");
  a_write_ready: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout) else $error("wr wait");
  a_read_wait: assert property (rdReq |=> rdAns) else $error("rd timing");
  a_resp_okay: assert property (hresp == 1'b0) else $error("resp");
endmodule // rtcg_chk
bind rtcg_top rtcg_chk rtcg_chk_i (.clk(clk), .arst_n(arst_n), .hsel(hsel), .hready(hready), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .status(status), .timeNow(timeNow),
  .rtcFixedCycleIrq(rtcFixedCycleIrq));
`default_nettype wire

// *** verification/rtcg_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtcg_top_tb;
  import rtcg_pkg::*;
  localparam int SEC = 200;
  logic clk, arst_n, hwrite, hreadyout, hresp, irqPulse, irqReq, hz;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  rtcg_status_t status;
  rtcg_time_t timeNow, held;
  int failures = 0;
  int n_checks = 0;
  rtcg_top #(.SEC_CYCLES_P(SEC)) rtcg_top_i (.clk(clk), .arst_n(arst_n), .hsel(1'b1), .haddr({24'h0, haddr}),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .status(status), .timeNow(timeNow),
    .rtcFixedCycleIrq(irqPulse), .rtcIrqRequest(irqReq), .rtc1HzOut(hz));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single AHB transfer; read data lands in rd
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_reset;
    xf(1'b0, PCE_A_OFFSET, 0);
    chk({24'h0, PCE_A_RESET}, rd, "enable");
    xf(1'b0, IRQ_MASK_1H_OFFSET, 0);
    chk({24'h0, IRQ_MASK_1H_RESET}, rd, "mask");
    xf(1'b0, 8'h14, 0);
    chk(0, rd, "unmapped");
    chk(1, status.rtcInReset, "in reset");
  endtask
  task automatic t_gated;
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'h82);
    xf(1'b0, RTC_CTRL_A_OFFSET, 0);
    chk(0, rd, "ctrl while off");
  endtask
  task automatic t_enable;
    xf(1'b1, PCE_A_OFFSET, 32'h80);
    xf(1'b0, PCE_A_OFFSET, 0);
    chk(32'h80, rd, "enable");
    chk(3'b101, {status.rtcClockOn, status.rtcInReset, status.intervalTimerClockOn}, "gate");
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'hFF);
    xf(1'b0, RTC_CTRL_A_OFFSET, 0);
    chk(32'hAF, rd, "ctrl mask");
  endtask
  task automatic t_second;
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'h82);
    repeat (SEC + 20) if (irqPulse !== 1'b1) @(posedge clk);
    chk(1, irqPulse, "tick");
    chk(1, timeNow.sec, "sec");
    xf(1'b0, IRQ_REQ_1H_OFFSET, 0);
    chk(1, rd[RTC_IRQ_BIT], "pending");
    chk(0, irqReq, "masked");
    xf(1'b1, IRQ_MASK_1H_OFFSET, 32'hFD);
    xf(1'b0, IRQ_MASK_1H_OFFSET, 0);
    chk(1, irqReq, "unmasked");
    xf(1'b1, IRQ_REQ_1H_OFFSET, 0);
    xf(1'b0, IRQ_REQ_1H_OFFSET, 0);
    chk(0, rd[RTC_IRQ_BIT], "cleared");
    chk(0, irqReq, "req off");
  endtask
  // Half-second selection with the 1 Hz output on: pulses SEC/2 apart, output level flips between them
  task automatic t_half;
    int gap;
    logic h1;
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'hA1);
    repeat (SEC) if (irqPulse !== 1'b1) @(posedge clk);
    h1 = hz;
    gap = 1;
    @(posedge clk);
    repeat (SEC) if (irqPulse !== 1'b1) begin
      @(posedge clk);
      gap++;
    end
    chk(SEC / 2, gap, "half gap");
    chk(1, h1 ^ hz, "1 Hz out");
  endtask
  // Minute selection: the only pulse comes as the seconds wrap to zero
  task automatic t_minute;
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'h83);
    repeat (61 * SEC) if (irqPulse !== 1'b1) @(posedge clk);
    chk(1, irqPulse, "minute tick");
    chk(0, timeNow.sec, "minute sec");
    chk(1, timeNow.min, "minute");
  endtask
  task automatic t_stop;
    xf(1'b1, RTC_CTRL_A_OFFSET, 32'h02);
    @(posedge clk);
    held = timeNow;
    repeat (2 * SEC) @(posedge clk);
    chk(held, timeNow, "stopped");
    chk(0, status.rtcRunning, "run off");
    xf(1'b0, TIME_VIEW_OFFSET, 0);
    chk({10'h000, held}, rd, "time view");
  endtask
  task automatic t_off;
    xf(1'b1, PCE_A_OFFSET, 0);
    repeat (2) @(posedge clk);
    chk(0, timeNow, "time off");
    chk(1, status.rtcInReset, "reset off");
    xf(1'b0, RTC_CTRL_A_OFFSET, 0);
    chk(0, rd, "ctrl off");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    // The minute scenario alone needs about sixty seconds of SEC cycles
    repeat (100 * SEC) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 8'h0;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_gated();
    t_enable();
    t_second();
    t_half();
    t_minute();
    t_stop();
    t_off();
    tally_and_finish();
  end
endmodule // rtcg_top_tb
`default_nettype wire
